// ==== rtl/lnr_nak_reporter.sv ====
// Purpose: Checks link command messages and answers errors with NAK.
// Assumes: Characters arrive framed by sof (ENQ) and eof (last sum char).
// Notes:   Summary of operation follows.
`timescale 1ns/1ns
`include "lnr_defs.svh"
module lnr_nak_reporter
    import lnr_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    // Received character stream.
    input  wire lnr_rx_s    i_rx,
    output logic            o_rx_ready,
    // Operating mode fixed by the hardware run/stop selector.
    input  wire logic       i_runstop_hw,
    // Reply character stream.
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_data,
    input  wire logic       i_tx_ready,
    // Status.
    output logic [7:0]      o_nak_code,
    output logic            o_seq_init,
    output logic            o_msg_ok
);
    // True for an ASCII hexadecimal digit in upper case.
    function automatic logic is_hex(input logic [7:0] c);
        is_hex = (c >= `LNR_CHR_0 && c <= `LNR_CHR_9) ||
                 (c >= `LNR_CHR_A && c <= `LNR_CHR_FU);
    endfunction : is_hex
    // Value of one hex character.
    function automatic logic [3:0] hex_nib(input logic [7:0] c);
        hex_nib = (c <= `LNR_CHR_9) ? c[3:0] : 4'(c[3:0] + 4'h9);
    endfunction : hex_nib
    // Character for one nibble.
    function automatic logic [7:0] nib_chr(input logic [3:0] n);
        nib_chr = (n < 4'hA) ? (`LNR_CHR_0 | {4'h0, n})
                             : 8'(`LNR_CHR_A + {4'h0, n} - 8'h0A);
    endfunction : nib_chr
    // Command decode from its two characters.
    function automatic lnr_cmd_e dec_cmd(input logic [15:0] cc);
        case (cc)
            `LNR_CMD_BR: dec_cmd = CMD_BR;
            `LNR_CMD_WR: dec_cmd = CMD_WR;
            `LNR_CMD_BW: dec_cmd = CMD_BW;
            `LNR_CMD_WW: dec_cmd = CMD_WW;
            `LNR_CMD_QR: dec_cmd = CMD_QR;
            `LNR_CMD_QW: dec_cmd = CMD_QW;
            `LNR_CMD_RR: dec_cmd = CMD_RR;
            `LNR_CMD_RS: dec_cmd = CMD_RS;
            `LNR_CMD_TT: dec_cmd = CMD_TT;
            default:     dec_cmd = CMD_NONE;
        endcase
    endfunction : dec_cmd
    // Lowest code among the raised flags, none when all clear.
    function automatic logic [7:0] err_code(input lnr_err_s f);
        if (f.sum)         err_code = `LNR_ERR_SUM;
        else if (f.proto)  err_code = `LNR_ERR_PROTO;
        else if (f.area)   err_code = `LNR_ERR_AREA;
        else if (f.data)   err_code = `LNR_ERR_DATA;
        else if (f.ctlno)  err_code = `LNR_ERR_CTLNO;
        else if (f.remote) err_code = `LNR_ERR_REMOTE;
        else               err_code = `LNR_ERR_NONE;
    endfunction : err_code

    // Registered state and its next values.
    lnr_state_e state_r, state_nxt;       // Sequence state.
    logic [7:0] pos_r, pos_nxt;           // Index of next character after ENQ.
    logic [1:0] held_r, held_nxt;         // Characters held back from sum.
    logic [7:0] sum_r, sum_nxt;           // Running modulo-256 sum.
    logic [7:0] d1_r, d1_nxt;             // Previous character.
    logic [7:0] d2_r, d2_nxt;             // Character two back.
    logic [7:0] stn0_r, stn0_nxt;         // Station number, first char.
    logic [7:0] stn1_r, stn1_nxt;         // Station number, second char.
    logic [7:0] cmdc_r, cmdc_nxt;         // First command character.
    lnr_cmd_e   cmd_r, cmd_nxt;           // Decoded command.
    lnr_err_s   flags_r, flags_nxt;       // Sticky message errors.
    logic [2:0] idx_r, idx_nxt;           // Reply character index.
    logic [7:0] code_r, code_nxt;         // Code being reported.
    logic       txv_r, txv_nxt;           // Reply character valid.
    logic [7:0] txd_r, txd_nxt;           // Reply character.
    logic       rdy_r, rdy_nxt;           // Ready for received characters.
    logic       init_r, init_nxt;         // Sequence initialised pulse.
    logic       ok_r, ok_nxt;             // Clean message pulse.
    // Combinational helpers.
    logic       acc;                      // Character taken this cycle.
    logic [7:0] bpos;                     // Position inside the body.
    logic [7:0] devlen;                   // Device field length.
    logic       has_dev;                  // Command carries a device.
    logic       is_wr;                    // Command carries write data.
    logic [7:0] sum_fin;                  // Sum over covered characters.
    logic       sum_ok;                   // Received sum field matches.

    // Field decode for the current character and command.
    always_comb begin
        acc     = rdy_r && i_rx.valid;
        bpos    = 8'(pos_r - `LNR_POS_BODY);
        devlen  = (cmd_r == CMD_QR || cmd_r == CMD_QW) ? `LNR_DEV_LONG
                                                       : `LNR_DEV_SHORT;
        has_dev = (cmd_r >= CMD_BR) && (cmd_r <= CMD_QW);
        is_wr   = (cmd_r == CMD_BW) || (cmd_r == CMD_WW) ||
                  (cmd_r == CMD_QW);
        // The last two characters are the sum field, so they stay out.
        sum_fin = (held_r == 2'h2) ? 8'(sum_r + d2_r) : sum_r;
        sum_ok  = (held_r != 2'h0) && is_hex(d1_r) && is_hex(i_rx.data)
               && ({hex_nib(d1_r), hex_nib(i_rx.data)} == sum_fin);
    end

    // Next-state logic for the whole message sequence.
    always_comb begin
        state_nxt = state_r;  pos_nxt  = pos_r;   held_nxt = held_r;
        sum_nxt   = sum_r;    d1_nxt   = d1_r;    d2_nxt   = d2_r;
        stn0_nxt  = stn0_r;   stn1_nxt = stn1_r;  cmdc_nxt = cmdc_r;
        cmd_nxt   = cmd_r;    flags_nxt = flags_r; idx_nxt = idx_r;
        code_nxt  = code_r;   txv_nxt  = txv_r;   txd_nxt  = txd_r;
        init_nxt  = 1'b0;
        ok_nxt    = 1'b0;
        case (state_r)
            ST_IDLE, ST_RECV: begin
                if (acc && i_rx.sof) begin
                    // A new start always begins a fresh message.
                    state_nxt   = ST_RECV;
                    pos_nxt     = 8'h00;
                    held_nxt    = 2'h0;
                    sum_nxt     = 8'h00;
                    cmd_nxt     = CMD_NONE;
                    flags_nxt   = '0;
                    // Any other opening means another procedure.
                    flags_nxt.proto = (i_rx.data != `LNR_CHR_ENQ);
                end else if (acc && state_r == ST_RECV) begin
                    // Saturate so a runaway message cannot wrap.
                    if (pos_r != 8'hFF) pos_nxt = 8'(pos_r + 8'h01);
                    if (held_r == 2'h2) sum_nxt = 8'(sum_r + d2_r);
                    else held_nxt = 2'(held_r + 2'h1);
                    d2_nxt = d1_r;
                    d1_nxt = i_rx.data;
                    if (pos_r == 8'h00) stn0_nxt = i_rx.data;
                    if (pos_r == 8'h01) stn1_nxt = i_rx.data;
                    if ((pos_r == `LNR_POS_CTL0 || pos_r == `LNR_POS_CTL1)
                        && i_rx.data != `LNR_CHR_F)
                        flags_nxt.ctlno = 1'b1;
                    if (pos_r == `LNR_POS_CMD0) cmdc_nxt = i_rx.data;
                    if (pos_r == `LNR_POS_CMD1) begin
                        cmd_nxt = dec_cmd({cmdc_r, i_rx.data});
                        if (dec_cmd({cmdc_r, i_rx.data}) == CMD_NONE)
                            flags_nxt.proto = 1'b1;
                        if ((dec_cmd({cmdc_r, i_rx.data}) == CMD_RR ||
                             dec_cmd({cmdc_r, i_rx.data}) == CMD_RS) &&
                            i_runstop_hw)
                            flags_nxt.remote = 1'b1;
                    end
                    if (pos_r >= `LNR_POS_BODY && has_dev) begin
                        // Device letter, then decimal device number.
                        if (bpos == 8'h00 &&
                            !(i_rx.data inside {8'h58, 8'h59, 8'h4D,
                              8'h53, 8'h54, 8'h43, 8'h44}))
                            flags_nxt.area = 1'b1;
                        if (bpos != 8'h00 && bpos < devlen &&
                            !(i_rx.data >= `LNR_CHR_0 &&
                              i_rx.data <= `LNR_CHR_9))
                            flags_nxt.area = 1'b1;
                        if (is_wr && bpos >= 8'(devlen + `LNR_CNT_LEN)
                            && !is_hex(i_rx.data))
                            flags_nxt.data = 1'b1;
                    end
                    if (i_rx.eof) begin
                        state_nxt = ST_CHECK;
                        if (!sum_ok) flags_nxt.sum = 1'b1;
                        // Too few characters for the device field.
                        if (has_dev && ({1'b0, pos_r} + 9'h001) <
                            ({1'b0, `LNR_POS_BODY} + {1'b0, devlen} +
                             {1'b0, `LNR_SUM_LEN}))
                            flags_nxt.area = 1'b1;
                    end
                end
            end
            ST_CHECK: begin
                if (err_code(flags_r) != `LNR_ERR_NONE) begin
                    code_nxt  = err_code(flags_r);
                    init_nxt  = 1'b1;
                    txv_nxt   = 1'b1;
                    txd_nxt   = `LNR_CHR_NAK;
                    idx_nxt   = 3'h0;
                    state_nxt = ST_REPLY;
                end else begin
                    ok_nxt    = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_REPLY: begin
                // Reply: NAK, station, controller, code high, code low.
                if (i_tx_ready) begin
                    idx_nxt = 3'(idx_r + 3'h1);
                    case (idx_r)
                        3'h0:    txd_nxt = stn0_r;
                        3'h1:    txd_nxt = stn1_r;
                        3'h2:    txd_nxt = `LNR_CHR_F;
                        3'h3:    txd_nxt = `LNR_CHR_F;
                        3'h4:    txd_nxt = nib_chr(code_r[7:4]);
                        3'h5:    txd_nxt = nib_chr(code_r[3:0]);
                        default: txd_nxt = txd_r;
                    endcase
                    if (idx_r == `LNR_REPLY_LAST) begin
                        txv_nxt   = 1'b0;
                        state_nxt = ST_IDLE;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Input is held off while checking and replying.
        rdy_nxt = (state_nxt == ST_IDLE) || (state_nxt == ST_RECV);
    end

    // Registers only; reset puts the sequence at idle and ready.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;  pos_r  <= 8'h00;  held_r <= 2'h0;
            sum_r   <= 8'h00;    d1_r   <= 8'h00;  d2_r   <= 8'h00;
            stn0_r  <= 8'h00;    stn1_r <= 8'h00;  cmdc_r <= 8'h00;
            cmd_r   <= CMD_NONE; flags_r <= '0;    idx_r  <= 3'h0;
            code_r  <= 8'h00;    txv_r  <= 1'b0;   txd_r  <= 8'h00;
            rdy_r   <= 1'b1;     init_r <= 1'b0;   ok_r   <= 1'b0;
        end else begin
            state_r <= state_nxt; pos_r  <= pos_nxt;  held_r <= held_nxt;
            sum_r   <= sum_nxt;   d1_r   <= d1_nxt;   d2_r   <= d2_nxt;
            stn0_r  <= stn0_nxt;  stn1_r <= stn1_nxt; cmdc_r <= cmdc_nxt;
            cmd_r   <= cmd_nxt;   flags_r <= flags_nxt; idx_r <= idx_nxt;
            code_r  <= code_nxt;  txv_r  <= txv_nxt;  txd_r  <= txd_nxt;
            rdy_r   <= rdy_nxt;   init_r <= init_nxt; ok_r   <= ok_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign o_rx_ready = rdy_r;
    assign o_tx_valid = txv_r;
    assign o_tx_data  = txd_r;
    assign o_nak_code = code_r;
    assign o_seq_init = init_r;
    assign o_msg_ok   = ok_r;

    // An error verdict starts a NAK reply and reinitialises.
    property p_nak_start;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_CHECK && flags_r != '0 |=>
            o_tx_valid && o_tx_data == `LNR_CHR_NAK && o_seq_init;
    endproperty
    a_nak_start: assert property (p_nak_start)
        else $error("NAK reply did not start after an error");
    property p_lowest;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_CHECK && !flags_r.sum && flags_r.proto &&
        flags_r.ctlno |=> o_nak_code == `LNR_ERR_PROTO;
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("Lower error code not preferred");
    property p_back_idle;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_REPLY && o_tx_valid && i_tx_ready &&
        idx_r == `LNR_REPLY_LAST |=>
            state_r == ST_IDLE && !o_tx_valid && o_rx_ready;
    endproperty
    a_back_idle: assert property (p_back_idle)
        else $error("Sequence not back at idle after NAK");
    property p_sum;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_CHECK && flags_r.sum |=>
            o_nak_code == `LNR_ERR_SUM ##1
            o_tx_data == ($past(i_tx_ready) ? stn0_r : `LNR_CHR_NAK);
    endproperty
    a_sum: assert property (p_sum)
        else $error("Sum error not reported as 02");
    property p_proto;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_RECV && acc && !i_rx.sof && i_rx.eof && sum_ok &&
        !flags_r.sum && pos_r > `LNR_POS_CMD1 && cmd_r == CMD_NONE
        |=> ##1 o_nak_code == `LNR_ERR_PROTO;
    endproperty
    a_proto: assert property (p_proto)
        else $error("Unknown command not reported as 03");
    property p_area;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_CHECK && flags_r.area && !flags_r.sum &&
        !flags_r.proto |=> o_nak_code == `LNR_ERR_AREA;
    endproperty
    a_area: assert property (p_area)
        else $error("Device field error not reported as 06");
    property p_data;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_CHECK && flags_r.data &&
        !(flags_r.sum || flags_r.proto || flags_r.area)
        |=> o_nak_code == `LNR_ERR_DATA;
    endproperty
    a_data: assert property (p_data)
        else $error("Write data error not reported as 07");
    property p_ctlno;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_CHECK && flags_r.ctlno &&
        !(flags_r.sum || flags_r.proto || flags_r.area || flags_r.data)
        |=> o_nak_code == `LNR_ERR_CTLNO;
    endproperty
    a_ctlno: assert property (p_ctlno)
        else $error("Controller number error not reported as 0A");
    property p_remote;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_CHECK && flags_r == 6'h01
        |=> o_nak_code == `LNR_ERR_REMOTE && !o_msg_ok;
    endproperty
    a_remote: assert property (p_remote)
        else $error("Refused run/stop not reported as 18");
    property p_sum_flag;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_r == ST_RECV && acc && !i_rx.sof && i_rx.eof &&
        !sum_ok |=> flags_r.sum && state_r == ST_CHECK;
    endproperty
    a_sum_flag: assert property (p_sum_flag)
        else $error("Sum mismatch not flagged");
endmodule : lnr_nak_reporter

// ==== rtl/lnr_defs.svh ====
// Purpose: Constants for the link NAK error reporter.
// Assumes: ASCII characters on an 8-bit receive stream.
// Notes:   Codes are the values sent after NAK.
`ifndef LNR_DEFS_SVH
`define LNR_DEFS_SVH
// Control characters and the letter F.
`define LNR_CHR_ENQ    8'h05
`define LNR_CHR_NAK    8'h15
`define LNR_CHR_F      8'h46
// ASCII digit and letter bounds.
`define LNR_CHR_0      8'h30
`define LNR_CHR_9      8'h39
`define LNR_CHR_A      8'h41
`define LNR_CHR_FU     8'h46
// Error codes.
`define LNR_ERR_NONE   8'h00
`define LNR_ERR_SUM    8'h02
`define LNR_ERR_PROTO  8'h03
`define LNR_ERR_AREA   8'h06
`define LNR_ERR_DATA   8'h07
`define LNR_ERR_CTLNO  8'h0A
`define LNR_ERR_REMOTE 8'h18
// Controller number that addresses this station.
`define LNR_CTL_SELF   8'hFF
// Field positions, counted from the first character after ENQ.
`define LNR_POS_CTL0   8'h02
`define LNR_POS_CTL1   8'h03
`define LNR_POS_CMD0   8'h04
`define LNR_POS_CMD1   8'h05
`define LNR_POS_BODY   8'h07
// Device field lengths, count field and sum field lengths.
`define LNR_DEV_SHORT  8'h05
`define LNR_DEV_LONG   8'h07
`define LNR_CNT_LEN    8'h02
`define LNR_SUM_LEN    8'h02
// Last character index of the NAK reply.
`define LNR_REPLY_LAST 3'h6
// Command character pairs.
`define LNR_CMD_BR     16'h4252
`define LNR_CMD_WR     16'h5752
`define LNR_CMD_BW     16'h4257
`define LNR_CMD_WW     16'h5757
`define LNR_CMD_QR     16'h5152
`define LNR_CMD_QW     16'h5157
`define LNR_CMD_RR     16'h5252
`define LNR_CMD_RS     16'h5253
`define LNR_CMD_TT     16'h5454
`endif

// ==== rtl/lnr_pkg.sv ====
// Purpose: Types for the link NAK error reporter.
// Assumes: Nothing beyond the constants header.
// Notes:   Error flags are ordered lowest code first.
package lnr_pkg;
    // One received character with its frame marks.
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } lnr_rx_s;
    // Message sequence states, Gray along idle-receive-check-reply.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_RECV  = 2'h1,
        ST_CHECK = 2'h3,
        ST_REPLY = 2'h2
    } lnr_state_e;
    // Decoded commands.
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0, CMD_BR = 4'h1, CMD_WR = 4'h2, CMD_BW = 4'h3,
        CMD_WW   = 4'h4, CMD_QR = 4'h5, CMD_QW = 4'h6, CMD_RR = 4'h7,
        CMD_RS   = 4'h8, CMD_TT = 4'h9
    } lnr_cmd_e;
    // Sticky error flags of one message.
    typedef struct packed {
        logic sum;
        logic proto;
        logic area;
        logic data;
        logic ctlno;
        logic remote;
    } lnr_err_s;
endpackage : lnr_pkg

// ==== tb/lnr_host_model.sv ====
// Purpose: Host side of the link: sends framed messages, sinks replies.
// Assumes: Messages are built by the caller, ENQ first, sum last.
// Notes:   The reply sink stalls every other cycle to test holding.
`timescale 1ns/1ns
module lnr_host_model
    import lnr_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    // Message stream towards the device.
    output lnr_rx_s         o_rx,
    input  wire logic       i_rx_ready,
    // Reply stream from the device.
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready
);
    logic [7:0] rx_q[$];  // Reply characters taken so far.
    int         ovf = 0;  // Bounded waits that ran out.

    // Idle line carries no valid character.
    initial begin
        o_rx = '0;
    end

    // Sink takes a reply char on each ready edge; half rate on purpose.
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_ready <= 1'b0;
        end else begin
            if (i_tx_valid && o_tx_ready) begin
                rx_q.push_back(i_tx_data);
            end
            o_tx_ready <= ~o_tx_ready;
        end
    end

    // Each char is held until taken; the released line shows inverse data.
    task automatic send(input logic [7:0] m[$], input bit eof_en);
        int w;
        @(posedge i_mclk);
        for (int i = 0; i < m.size(); i++) begin
            o_rx <= '{1'b1, i == 0, eof_en && (i == m.size() - 1), m[i]};
            w = 0;
            do begin
                @(posedge i_mclk);
                w++;
            end while (!i_rx_ready && w < 50);
            if (w >= 50) ovf++;
        end
        o_rx <= '{1'b0, 1'b0, 1'b0, ~m[m.size() - 1]};
    endtask : send
endmodule : lnr_host_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the link NAK error reporter.
// Assumes: Host model drives messages; rows hold expected verdicts.
// Notes:   Code 00 in a row means the message must pass.
`timescale 1ns/1ns
`include "lnr_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb
    import lnr_pkg::*;
;
    typedef struct {
        string      ctl;   // Controller number chars.
        string      cmd;   // Command chars.
        string      body;  // Device, count and data chars.
        bit         bad;   // Corrupt the sum field.
        bit         hw;    // Hardware selector fixes the mode.
        logic [7:0] code;  // Expected code, 00 when clean.
    } lnr_row_s;

    logic       i_mclk = 1'b0;     // System clock.
    logic       i_rst_n = 1'b0;    // Active low reset.
    logic       i_runstop_hw = 1'b0;
    lnr_rx_s    rx;                // Stream from the host model.
    logic       o_rx_ready, o_tx_valid, tx_ready, o_seq_init, o_msg_ok;
    logic [7:0] o_tx_data, o_nak_code;
    logic [7:0] msg_q[$];          // Message under construction.
    int         err_total = 0;
    int         cmp_count = 0;

    lnr_row_s rows[] = '{
        '{"FF", "BR", "D000001", 0, 0, 8'h00},
        '{"FF", "WR", "D000001", 0, 0, 8'h00},
        '{"FF", "BW", "M0000011", 0, 0, 8'h00},
        '{"FF", "WW", "D0000010A1B", 0, 0, 8'h00},
        '{"FF", "QR", "D00000001", 0, 0, 8'h00},
        '{"FF", "QW", "D000000010A1B", 0, 0, 8'h00},
        '{"FF", "RR", "D000001", 0, 0, 8'h00},
        '{"FF", "RS", "D000001", 0, 0, 8'h00},
        '{"FF", "TT", "D000001", 0, 0, 8'h00},
        '{"FF", "BR", "D000001", 1, 0, 8'h02},
        '{"FF", "ZZ", "D000001", 0, 0, 8'h03},
        '{"FF", "BR", "Q000001", 0, 0, 8'h06},
        '{"FF", "BR", "D00", 0, 0, 8'h06},
        '{"FF", "WW", "D0000011G2B", 0, 0, 8'h07},
        '{"FE", "BR", "D000001", 0, 0, 8'h0A},
        '{"FF", "RR", "D000001", 0, 1, 8'h18},
        '{"FF", "RS", "D000001", 0, 1, 8'h18},
        '{"FE", "ZZ", "D000001", 1, 0, 8'h02},
        '{"FE", "BR", "Q000001", 0, 1, 8'h06},
        '{"FE", "ZZ", "D000001", 0, 0, 8'h03}
    };

    // Half period of 10 ns gives the 50 MHz system clock.
    always #10 i_mclk = ~i_mclk;

    lnr_nak_reporter u_dut (
        .i_mclk       (i_mclk),
        .i_rst_n      (i_rst_n),
        .i_rx         (rx),
        .o_rx_ready   (o_rx_ready),
        .i_runstop_hw (i_runstop_hw),
        .o_tx_valid   (o_tx_valid),
        .o_tx_data    (o_tx_data),
        .i_tx_ready   (tx_ready),
        .o_nak_code   (o_nak_code),
        .o_seq_init   (o_seq_init),
        .o_msg_ok     (o_msg_ok)
    );

    lnr_host_model u_host (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .o_rx       (rx),
        .i_rx_ready (o_rx_ready),
        .i_tx_valid (o_tx_valid),
        .i_tx_data  (o_tx_data),
        .o_tx_ready (tx_ready)
    );

    // Upper-case hex digit of one nibble.
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction : hx

    // Closing report; also the exit taken by any exhausted wait in run_row.
    task automatic print_verdict();
        err_total += u_host.ovf;
        $display("Errors %0d, checks %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // Build, send and judge one message, including the NAK reply.
    task automatic run_row(input lnr_row_s r);
        logic [7:0] s;
        int         w;
        logic [7:0] rq[$];  // Snapshot of the reply characters.
        s = 8'h00;
        msg_q = {`LNR_CHR_ENQ, 8'h30, 8'h30, r.ctl[0], r.ctl[1],
                 r.cmd[0], r.cmd[1], 8'h30};
        foreach (r.body[i]) msg_q.push_back(r.body[i]);
        for (int i = 1; i < msg_q.size(); i++) s += msg_q[i];
        s ^= {7'h00, r.bad};
        msg_q.push_back(hx(s[7:4]));
        msg_q.push_back(hx(s[3:0]));
        u_host.rx_q = {};
        i_runstop_hw <= r.hw;
        u_host.send(msg_q, 1'b1);
        // Verdict pulse is seen exactly once, a cycle after the sum.
        w = 0;
        while (!(o_seq_init || o_msg_ok) && w < 20) begin
            @(posedge i_mclk);
            w++;
        end
        if (w >= 20) begin
            err_total++;
            print_verdict();
        end
        `CHK({o_seq_init, o_msg_ok}, (r.code == 8'h00) ? 2'b01 : 2'b10)
        if (r.code != 8'h00) begin
            `CHK(o_nak_code, r.code)
            w = 0;
            while (u_host.rx_q.size() < 7 && w < 40) begin
                @(posedge i_mclk);
                w++;
            end
            if (w >= 40) begin
                err_total++;
                print_verdict();
            end
            rq = u_host.rx_q;
            `CHK({rq[0], rq[1], rq[2]}, {`LNR_CHR_NAK, 16'h3030})
            `CHK({rq[3], rq[4]}, 16'h4646)
            `CHK({rq[5], rq[6]}, {hx(r.code[7:4]), hx(r.code[3:0])})
        end
        w = 0;
        while (!o_rx_ready && w < 20) begin
            @(posedge i_mclk);
            w++;
        end
        if (w >= 20) begin
            err_total++;
            print_verdict();
        end
        `CHK(o_tx_valid, 1'b0)
    endtask : run_row

    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        // A clean message leaves the last code in place.
        run_row(rows[14]);
        run_row(rows[0]);
        `CHK(o_nak_code, 8'h0A)
        // A new opening char in mid-message restarts the message.
        u_host.send({`LNR_CHR_ENQ, 8'h30, 8'h30, 8'h46}, 1'b0);
        run_row(rows[1]);
        // Mid-run reset clears the held code and opens the receiver.
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        @(posedge i_mclk);
        @(posedge i_mclk);
        `CHK({o_rx_ready, o_tx_valid, o_nak_code}, {2'b10, 8'h00})
        i_rst_n <= 1'b1;
        run_row(rows[10]);
        print_verdict();
    end
endmodule : tb
